//--- hdl/slm_top.sv
/*
 * Shaft load monitor: four threshold channels on the shaft power, with
 * manual levels or autoset margins, per-channel delay and action, and
 * trip latching with reset and restart sequencing.
 * Assumes all inputs synchronous to clk_sys; shaft power and levels are
 * whole percent of nominal motor power.
 */
`timescale 1ns/1ps
`include "slm_consts.svh"

module slm_top #(
    parameter int PW       = `SLM_PW,
    parameter int DW       = `SLM_DW,
    parameter int TICK_CYC = `SLM_TICK_CYC
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    input  wire logic                clk_en,
    // Run state from the sequencer
    input  wire logic                motor_running,
    input  wire logic                in_stop_ramp,
    input  wire logic                in_jog,
    input  wire logic                in_brake,
    input  wire logic                start_cmd,
    input  wire logic                trip_reset,
    // Load from the estimator, percent of nominal
    input  wire logic [PW-1:0]       shaft_power,
    // Settings
    input  wire logic [DW-1:0]       start_delay_ms,
    input  wire logic [3:0]          level_wr,
    input  wire logic [PW-1:0]       level_data,
    input  wire logic [4*PW-1:0]     margin,
    input  wire logic [4*DW-1:0]     delay_ms,
    input  wire logic [7:0]          action,
    // Autoset commands
    input  wire logic                autoset_cmd,
    input  wire logic                autoset_din,
    // Indications and relay sources
    output logic [3:0]               relay_src,
    output logic                     overload_early_warning_msg,
    output logic                     underload_early_warning_msg,
    output logic                     warning_any,
    output logic                     supervision_active,
    output logic [PW-1:0]            normal_load,
    output logic                     normal_load_valid,
    // Trip outputs to the trip handler
    output logic                     hard_trip_stop,
    output logic                     soft_trip_stop,
    output logic                     run_permit
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    // Overload channels are the two lowest indices
    function automatic logic is_ovl(input int ch);
        return (ch == `SLM_CH_OVL_ALARM) || (ch == `SLM_CH_OVL_PRE);
    endfunction

    function automatic slm_pkg::slm_action_e act_of(input int ch,
                                                    input logic [7:0] a);
        return slm_pkg::slm_action_e'(a[2*ch +: 2]);
    endfunction

    // ------------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic        ms_tick;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            tick_cnt <= '0;
        else if (clk_en)
            tick_cnt <= (tick_cnt >= 32'(TICK_CYC - 1)) ? '0
                                                        : tick_cnt + 1'b1;
    end
    assign ms_tick = (tick_cnt >= 32'(TICK_CYC - 1));

    // ------------------------------------------------------------------
    // Supervision enable
    // ------------------------------------------------------------------
    logic [DW-1:0] start_elapsed;
    logic          start_done;
    logic          sup_en;

    // Start delay counts from the start of a run; idle restarts it
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            start_elapsed <= '0;
        else if (clk_en)
        begin
            if (!motor_running)
                start_elapsed <= '0;
            else if (ms_tick && start_elapsed != '1)
                start_elapsed <= start_elapsed + 1'b1;
        end
    end
    // One tick beyond the delay, as the first tick may come at once
    assign start_done = (start_delay_ms == '0)
                        || (start_elapsed > start_delay_ms);
    // Stop ramp, jog and brake mask every channel; the start delay keeps counting
    assign sup_en = motor_running && start_done && !in_stop_ramp
                    && !in_jog && !in_brake;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            supervision_active <= 1'b0;
        else if (clk_en)
            supervision_active <= sup_en;
    end

    // ------------------------------------------------------------------
    // Reference load and levels
    // ------------------------------------------------------------------
    logic          din_prev;
    logic          autoset_go;
    logic [PW-1:0] man_level [4];
    logic [PW-1:0] thr       [4];

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            din_prev <= 1'b0;
        else if (clk_en)
            din_prev <= autoset_din;
    end
    // Edge only, a held input must not re-capture; level write wins
    assign autoset_go = (autoset_cmd || (autoset_din && !din_prev))
                        && motor_running && !(|level_wr);

    // Capture reference; any direct level write turns it off
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            normal_load       <= '0;
            normal_load_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            if (|level_wr)
                normal_load_valid <= 1'b0;
            else if (autoset_go)
            begin
                normal_load       <= shaft_power;
                normal_load_valid <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-channel thresholds, conditions and timers
    // ------------------------------------------------------------------
    logic [3:0] ch_cond;
    logic [3:0] fired;

    generate
        for (genvar c = 0; c < `SLM_CH_N; c++)
        begin : g_ch
            logic [PW:0] sum;
            logic [PW:0] dif;

            // Reset levels never trigger: overload at top, underload zero
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                    man_level[c] <= is_ovl(c) ? '1 : '0;
                else if (clk_en && level_wr[c])
                    man_level[c] <= level_data;
            end

            assign sum = {1'b0, normal_load} + {1'b0, margin[c*PW +: PW]};
            assign dif = {1'b0, normal_load} - {1'b0, margin[c*PW +: PW]};

            // Margins saturate so a big margin cannot wrap around
            always_comb
            begin
                if (!normal_load_valid)
                    thr[c] = man_level[c];
                else if (is_ovl(c))
                    thr[c] = sum[PW] ? '1 : sum[PW-1:0];
                else
                    thr[c] = dif[PW] ? '0 : dif[PW-1:0];
            end

            // Percent units on both sides, so compare directly
            assign ch_cond[c] = is_ovl(c) ? (shaft_power > thr[c])
                                          : (shaft_power < thr[c]);

            slm_chan_timer #(
                .DW       (DW)
            ) u_timer (
                .clk_sys  (clk_sys),
                .sys_rst  (sys_rst),
                .clk_en   (clk_en),
                .ms_tick  (ms_tick),
                .delay_ms (delay_ms[c*DW +: DW]),
                .cond     (ch_cond[c]),
                .enable   (sup_en),
                .fired    (fired[c])
            );

            // Relay source: active unless the channel is set to ignore
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                    relay_src[c] <= 1'b0;
                else if (clk_en)
                    relay_src[c] <= fired[c]
                        && act_of(c, action) != slm_pkg::slm_act_none;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Action decode
    // ------------------------------------------------------------------
    logic [3:0] warn_hit;
    logic       soft_hit;
    logic       hard_hit;

    always_comb
    begin
        warn_hit = '0;
        soft_hit = 1'b0;
        hard_hit = 1'b0;
        for (int c = 0; c < `SLM_CH_N; c++)
        begin
            warn_hit[c] = fired[c]
                          && act_of(c, action) == slm_pkg::slm_act_warn;
            soft_hit |= fired[c]
                        && act_of(c, action) == slm_pkg::slm_act_soft;
            hard_hit |= fired[c]
                        && act_of(c, action) == slm_pkg::slm_act_hard;
        end
    end

    // Warnings follow the condition, no latch, so they clear alone
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            overload_early_warning_msg  <= 1'b0;
            underload_early_warning_msg <= 1'b0;
            warning_any                 <= 1'b0;
        end
        else if (clk_en)
        begin
            overload_early_warning_msg  <= warn_hit[`SLM_CH_OVL_PRE];
            underload_early_warning_msg <= warn_hit[`SLM_CH_UNL_PRE];
            warning_any                 <= |warn_hit;
        end
    end

    // ------------------------------------------------------------------
    // Trip latch and restart sequence
    // ------------------------------------------------------------------
    slm_pkg::slm_trip_e trip_st;

    // Hard wins over soft when both fire together
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            trip_st        <= slm_pkg::slm_st_ok;
            hard_trip_stop <= 1'b0;
            soft_trip_stop <= 1'b0;
            run_permit     <= 1'b1;
        end
        else if (clk_en)
        begin
            case (trip_st)
            slm_pkg::slm_st_ok:
                if (hard_hit || soft_hit)
                begin
                    trip_st        <= slm_pkg::slm_st_tripped;
                    hard_trip_stop <= hard_hit;
                    soft_trip_stop <= !hard_hit;
                    run_permit     <= 1'b0;
                end
            slm_pkg::slm_st_tripped:
                if (trip_reset)
                begin
                    trip_st        <= slm_pkg::slm_st_wait_start;
                    hard_trip_stop <= 1'b0;
                    soft_trip_stop <= 1'b0;
                end
            slm_pkg::slm_st_wait_start:
                if (start_cmd)
                begin
                    trip_st    <= slm_pkg::slm_st_ok;
                    run_permit <= 1'b1;
                end
            default:
                trip_st <= slm_pkg::slm_st_ok;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_inhibit_quiet: assert property (
        (clk_en && (in_stop_ramp || in_jog || in_brake)) |=> fired == 4'h0)
        else $error("channel fired while inhibited");
    chk_start_hold: assert property (
        (motor_running && start_elapsed < start_delay_ms) |-> !sup_en)
        else $error("supervision before start delay");
    chk_zero_delay: assert property (
        (clk_en && sup_en && ch_cond[0] && delay_ms[DW-1:0] == '0)
        |=> fired[0])
        else $error("zero delay did not act at once");
    chk_autoset_take: assert property (
        (clk_en && autoset_go)
        |=> normal_load_valid && normal_load == $past(shaft_power))
        else $error("autoset did not capture shaft power");
    chk_level_override: assert property (
        (clk_en && |level_wr) |=> !normal_load_valid)
        else $error("level write left reference on");
    chk_hard_coast: assert property (
        (clk_en && trip_st == slm_pkg::slm_st_ok && hard_hit)
        |=> hard_trip_stop && !soft_trip_stop && !run_permit)
        else $error("hard trip not taken");
    chk_trip_restart: assert property (
        (trip_st == slm_pkg::slm_st_tripped && clk_en && trip_reset)
        |=> !run_permit ##0 trip_st == slm_pkg::slm_st_wait_start)
        else $error("restart without new start");
    chk_warn_clear: assert property (
        (clk_en && !ch_cond[1]) ##1 clk_en |=> !overload_early_warning_msg)
        else $error("warning did not clear itself");
    chk_no_early_fire: assert property (
        $rose(fired[0]) |-> $past(ch_cond[0] && sup_en
                                  && g_ch[0].u_timer.elapsed
                                     >= delay_ms[DW-1:0]))
        else $error("alarm fired before its delay");

    cov_autoset: cover property (clk_en && autoset_go);
    cov_warn: cover property (overload_early_warning_msg);
    cov_soft_trip: cover property ($rose(soft_trip_stop));
    cov_restart: cover property (trip_st == slm_pkg::slm_st_wait_start
                                 ##1 run_permit);

endmodule

//--- hdl/slm_consts.svh
/*
 * Constants of the shaft load monitor: channel indices, load scale, widths and
 * timing figures. Assumes the clock runs at 100 MHz.
 */
`ifndef SLM_CONSTS_SVH
`define SLM_CONSTS_SVH

// ----------------------------------------------------------------------
// Channels
// ----------------------------------------------------------------------
`define SLM_CH_N          4
`define SLM_CH_OVL_ALARM  0
`define SLM_CH_OVL_PRE    1
`define SLM_CH_UNL_PRE    2
`define SLM_CH_UNL_ALARM  3

// ----------------------------------------------------------------------
// Load scale and widths
// ----------------------------------------------------------------------
`define SLM_PW            16
`define SLM_NOMINAL_PCT   16'h0064
`define SLM_DW            16

// ----------------------------------------------------------------------
// Timing: the millisecond tick
// ----------------------------------------------------------------------
`define SLM_CLK_NS        10
`define SLM_TICK_NS       1000000
`define SLM_TICK_CYC      (`SLM_TICK_NS / `SLM_CLK_NS)

`endif

//--- hdl/slm_pkg.sv
/*
 * Types shared by the shaft load monitor files.
 * Assumes slm_consts.svh supplies every number.
 */
package slm_pkg;

    // Channel action, as chosen per channel
    typedef enum logic [1:0] {
        slm_act_none,
        slm_act_warn,
        slm_act_soft,
        slm_act_hard
    } slm_action_e;

    // Trip and restart sequence
    typedef enum logic [1:0] {
        slm_st_ok,
        slm_st_tripped,
        slm_st_wait_start
    } slm_trip_e;

endpackage

//--- hdl/slm_chan_timer.sv
/*
 * One persistence timer for one supervision channel.
 * Assumes a one-cycle millisecond tick from the parent, same clock.
 */
`timescale 1ns/1ps
`include "slm_consts.svh"

module slm_chan_timer #(
    parameter int DW = `SLM_DW
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    input  wire logic          clk_en,
    // Timing
    input  wire logic          ms_tick,
    input  wire logic [DW-1:0] delay_ms,
    // Condition
    input  wire logic          cond,
    input  wire logic          enable,
    // Result
    output logic               fired
);

    // ------------------------------------------------------------------
    // Persistence counter
    // ------------------------------------------------------------------
    logic [DW-1:0] elapsed;

    // Restarts whenever the condition drops or supervision stops
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            elapsed <= '0;
        else if (clk_en)
        begin
            if (!cond || !enable)
                elapsed <= '0;
            else if (ms_tick && elapsed != '1)
                elapsed <= elapsed + 1'b1;
        end
    end

    // Fires only after the full delay; zero delay fires at once.
    // The tick phase is free, so d ms need d+1 ticks to be sure; a
    // delay of all ones therefore never fires.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            fired <= 1'b0;
        else if (clk_en)
            fired <= cond && enable
                     && (delay_ms == '0 || elapsed > delay_ms);
    end

endmodule

//--- test/slm_seq_model.sv
/*
 * Behavioural run-state sequencer and shaft power estimator that stand
 * in front of the shaft load monitor.
 * Assumes bench requests change just after a falling edge of clk_sys.
 */
`timescale 1ns/1ps

module slm_seq_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Requests from the bench
    input  wire logic        run_req,
    input  wire logic [1:0]  inhibit_sel,
    input  wire logic [15:0] load_pct,
    input  wire logic        din_req,
    // Trip outputs of the monitor
    input  wire logic        hard_trip_stop,
    input  wire logic        soft_trip_stop,
    input  wire logic        run_permit,
    // Run state and load towards the monitor
    output logic             motor_running,
    output logic             in_stop_ramp,
    output logic             in_jog,
    output logic             in_brake,
    output logic [15:0]      shaft_power,
    output logic             autoset_din
);
    logic [2:0] ramp;

    // ------------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------------
    // Coast on hard trip, short stop ramp on soft trip, no restart
    // until the monitor permits it again
    always_ff @(negedge clk_sys)
    begin
        if (sys_rst)
        begin
            motor_running <= 1'b0;
            ramp          <= 3'h0;
        end
        else if (hard_trip_stop)
        begin
            motor_running <= 1'b0;
            ramp          <= 3'h0;
        end
        else if (soft_trip_stop && motor_running && ramp == 3'h0)
            ramp <= 3'h4;
        else if (ramp > 3'h1)
            ramp <= ramp - 3'h1;
        else if (ramp == 3'h1)
        begin
            motor_running <= 1'b0;
            ramp          <= 3'h0;
        end
        else
            motor_running <= run_req && run_permit;
    end

    // ------------------------------------------------------------------
    // Inhibit states, load and digital input
    // ------------------------------------------------------------------
    // Estimator reads zero at standstill, so stale load never leaks
    assign in_stop_ramp = (ramp != 3'h0) || (inhibit_sel == 2'h1);
    assign in_jog       = (inhibit_sel == 2'h2);
    assign in_brake     = (inhibit_sel == 2'h3);
    assign shaft_power  = motor_running ? load_pct : 16'h0000;
    assign autoset_din  = din_req;
endmodule

//--- test/shaft_load_monitor_tb.sv
/*
 * Self-checking bench for the shaft load monitor, with the sequencer
 * model on its run-state side. Assumes a 100 MHz clk_sys and a short
 * millisecond tick of four cycles.
 */
`timescale 1ns/1ps

module shaft_load_monitor_tb;
    localparam int TICK = 4;

    // ------------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------------
    logic        clk_sys     = 1'b0;
    logic        sys_rst     = 1'b1;
    logic [2:0]  cmd         = 3'h0;
    logic [3:0]  level_wr    = 4'h0;
    logic [15:0] level_data  = 16'h0000;
    logic        run_req     = 1'b0;
    logic [1:0]  inhibit_sel = 2'h0;
    logic [15:0] load_pct    = 16'h0000;
    logic        din_req     = 1'b0;
    // Actions, channel 3 down to channel 0
    logic [7:0]  act         = {slm_pkg::slm_act_soft, slm_pkg::slm_act_warn,
                                slm_pkg::slm_act_warn, slm_pkg::slm_act_hard};
    int          fail_count  = 0;
    int          n_compared  = 0;
    int          n;
    wire         motor_running, in_stop_ramp, in_jog, in_brake, autoset_din;
    wire  [15:0] shaft_power, normal_load;
    wire  [3:0]  relay_src;
    wire         ovl_ew, unl_ew, warning_any, supervision_active;
    wire         normal_load_valid, hard_trip_stop, soft_trip_stop;
    wire         run_permit;
    wire  [3:0]  watch = {supervision_active, hard_trip_stop,
                          soft_trip_stop, motor_running};

    // Clock
    always #5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // Design and sequencer model
    // ------------------------------------------------------------------
    slm_top #(.TICK_CYC(TICK)) i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
        .motor_running(motor_running), .in_stop_ramp(in_stop_ramp),
        .in_jog(in_jog), .in_brake(in_brake), .start_cmd(cmd[0]),
        .trip_reset(cmd[1]), .shaft_power(shaft_power),
        .start_delay_ms(16'h0002), .level_wr(level_wr),
        .level_data(level_data),
        .margin({16'h0028, 16'h000A, 16'h0005, 16'h000A}),
        .delay_ms({16'h0001, 16'h0000, 16'h0000, 16'h0003}),
        .action(act),
        .autoset_cmd(cmd[2]), .autoset_din(autoset_din),
        .relay_src(relay_src), .overload_early_warning_msg(ovl_ew),
        .underload_early_warning_msg(unl_ew), .warning_any(warning_any),
        .supervision_active(supervision_active),
        .normal_load(normal_load), .normal_load_valid(normal_load_valid),
        .hard_trip_stop(hard_trip_stop), .soft_trip_stop(soft_trip_stop),
        .run_permit(run_permit));

    slm_seq_model i_model (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .run_req(run_req),
        .inhibit_sel(inhibit_sel), .load_pct(load_pct), .din_req(din_req),
        .hard_trip_stop(hard_trip_stop), .soft_trip_stop(soft_trip_stop),
        .run_permit(run_permit), .motor_running(motor_running),
        .in_stop_ramp(in_stop_ramp), .in_jog(in_jog), .in_brake(in_brake),
        .shaft_power(shaft_power), .autoset_din(autoset_din));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bounded wait on one watched flag; n holds the cycles spent
    task automatic wait_hi(input int b, input int lim);
        n = 0;
        while (watch[b] !== 1'b1 && n < lim)
        begin
            cyc(1);
            n++;
        end
        if (n >= lim)
        begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, watch, 4'h1 << b);
            summarize();
        end
    endtask

    // One-cycle command: 0 start, 1 trip reset, 2 autoset
    task automatic pulse(input int b);
        cmd <= 3'h1 << b;
        cyc(1);
        cmd <= 3'h0;
        cyc(1);
    endtask

    task automatic set_level(input int c, input logic [15:0] v);
        level_wr   <= 4'h1 << c;
        level_data <= v;
        cyc(1);
        level_wr   <= 4'h0;
        cyc(1);
    endtask

    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        cyc(12);
        sys_rst <= 1'b0;
        cyc(1);
        check({relay_src, hard_trip_stop, soft_trip_stop}, 0);
        check({run_permit, normal_load_valid, warning_any}, 3'h4);
        set_level(0, 16'h0046);
        set_level(1, 16'h0041);
        set_level(2, 16'h001E);
        set_level(3, 16'h000A);
        load_pct <= 16'h0032;
        run_req  <= 1'b1;
        wait_hi(0, 20);
        wait_hi(3, 40);
        check(20'(n >= 2 * TICK && n <= 4 * TICK), 1);
        // Threshold itself is not a violation; one above warns at once
        load_pct <= 16'h0041;
        cyc(4);
        check({relay_src, ovl_ew, warning_any}, 0);
        load_pct <= 16'h0042;
        cyc(3);
        check({relay_src, ovl_ew, warning_any}, 6'h0B);
        load_pct <= 16'h0032;
        cyc(3);
        check({relay_src, ovl_ew, warning_any}, 0);
        load_pct <= 16'h0014;
        cyc(3);
        check({relay_src, unl_ew, hard_trip_stop}, 6'h12);
        // Set to no action, the channel reaches neither relay nor display
        act[5:4] <= 2'h0;
        cyc(3);
        check({relay_src, unl_ew}, 5'h00);
        load_pct <= 16'h0032;
        cyc(3);
        act[5:4] <= 2'h1;
        // Stop ramp, jog and brake each silence every channel
        for (int s = 1; s < 4; s++)
        begin
            inhibit_sel <= 2'(s);
            cyc(2);
            load_pct <= 16'h0042;
            cyc(4);
            check({supervision_active, relay_src, warning_any}, 0);
            load_pct    <= 16'h0032;
            inhibit_sel <= 2'h0;
            cyc(3);
        end
        wait_hi(3, 20);
        // Two short overloads; their sum would outlast the delay
        for (int p = 0; p < 2; p++)
        begin
            load_pct <= 16'h0050;
            cyc(10);
            load_pct <= 16'h0032;
            cyc(4);
        end
        check(hard_trip_stop, 0);
        load_pct <= 16'h0050;
        wait_hi(2, 30);
        check(20'(n >= 3 * TICK), 1);
        check({soft_trip_stop, run_permit, relay_src[0]}, 3'h1);
        load_pct <= 16'h0032;
        pulse(0);
        check({hard_trip_stop, run_permit}, 2'h2);
        pulse(1);
        check({hard_trip_stop, run_permit}, 2'h0);
        pulse(0);
        check(run_permit, 1);
        wait_hi(3, 40);
        // Autoset reference 55: pre-alarm moves from 65 down to 60
        load_pct <= 16'h0037;
        cyc(2);
        pulse(2);
        check({normal_load_valid, normal_load}, 20'h1_0037);
        load_pct <= 16'h003E;
        cyc(3);
        check(ovl_ew, 1);
        load_pct <= 16'h003C;
        cyc(3);
        check(ovl_ew, 0);
        // Input edge captures once; the held level captures nothing
        load_pct <= 16'h0046;
        din_req  <= 1'b1;
        cyc(4);
        check(normal_load, 16'h0046);
        load_pct <= 16'h004A;
        cyc(4);
        check({normal_load, ovl_ew}, 20'h0_008C);
        // Underload alarm at 70 - 40 ends in a soft trip
        load_pct <= 16'h0014;
        wait_hi(1, 20);
        check({hard_trip_stop, relay_src[3]}, 2'h1);
        set_level(0, 16'h0046);
        check(normal_load_valid, 0);
        din_req <= 1'b0;
        run_req <= 1'b0;
        cyc(2);
        summarize();
    end
endmodule
